// ===== rtl/cair_pkg.sv
// Purpose: shared constants and types for the accumulator and index register set
// Assumes: one core clock, synchronous active-high reset
// Notes: registers are reached only through the instruction-side ports
package cair_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned EXT_W = 20;
  localparam int unsigned QUEUE_BYTES = 3;
  localparam int unsigned QUEUE_DEPTH = 4;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [15:0] IDX_RESET = 16'h0000;
  localparam logic [19:0] EXT_RESET = 20'h00000;
  localparam int unsigned DACC_HI_LSB = 8;
  localparam int unsigned DACC_LO_LSB = 0;

  // register write selects
  typedef enum logic [2:0] {
    CAIR_WR_NONE = 3'h0,
    CAIR_WR_ACC_FIRST = 3'h1,
    CAIR_WR_ACC_SECOND = 3'h2,
    CAIR_WR_DOUBLE = 3'h3,
    CAIR_WR_INDEX_FIRST = 3'h4,
    CAIR_WR_INDEX_SECOND = 3'h5,
    CAIR_WR_EXT = 3'h6
  } cair_wr_t;

  // base register for effective address
  typedef enum logic [0:0] {
    CAIR_BASE_INDEX_FIRST = 1'h0,
    CAIR_BASE_INDEX_SECOND = 1'h1
  } cair_base_t;

  // offset source for effective address
  typedef enum logic [1:0] {
    CAIR_OFS_CONST = 2'h0,
    CAIR_OFS_ACC_FIRST = 2'h1,
    CAIR_OFS_ACC_SECOND = 2'h2,
    CAIR_OFS_DOUBLE = 2'h3
  } cair_ofs_t;

  // prefetch queue fill state, gray coded along the fill path
  typedef enum logic [1:0] {
    CAIR_Q_EMPTY = 2'b00,
    CAIR_Q_FILLING = 2'b01,
    CAIR_Q_READY = 2'b11
  } cair_qstate_t;
endpackage

// ===== rtl/cair_byte_queue.sv
// Purpose: small byte queue for program code prefetch
// Assumes: push and pop are taken only when allowed by full and empty
// Notes: head bytes come out of registers
`timescale 1ns/1ps
module cair_byte_queue
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic [1:0] pop_count,
  output logic [2:0] fill_reg,
  output logic [23:0] head_reg
);
  logic [7:0] mem_reg [0:cair_pkg::QUEUE_DEPTH-1];
  logic [2:0] fill_next;
  logic [2:0] after_pop;
  logic do_push;

  always_comb
  begin
    after_pop = fill_reg - {1'b0, pop_count};
    do_push = push && (after_pop < 3'(cair_pkg::QUEUE_DEPTH));
    fill_next = after_pop + {2'b00, do_push};
  end

  // shift register queue: entry 0 is oldest
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < cair_pkg::QUEUE_DEPTH; i++)
        mem_reg[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < cair_pkg::QUEUE_DEPTH; i++)
      begin
        if (do_push && (3'(i) == after_pop))
          mem_reg[i] <= push_data;
        else if ((i + pop_count) < cair_pkg::QUEUE_DEPTH)
          mem_reg[i] <= mem_reg[i + pop_count];
        else
          mem_reg[i] <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      fill_reg <= 3'h0;
    else
      fill_reg <= fill_next;
  end

  // head view registered from the next contents
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      head_reg <= 24'h000000;
    else
    begin
      for (int j = 0; j < 3; j++)
      begin
        if (do_push && (3'(j) == after_pop))
          head_reg[8*j +: 8] <= push_data;
        else if ((j + pop_count) < cair_pkg::QUEUE_DEPTH)
          head_reg[8*j +: 8] <= mem_reg[j + pop_count];
        else
          head_reg[8*j +: 8] <= 8'h00;
      end
    end
  end
endmodule

// ===== rtl/cair_regfile.sv
// Purpose: accumulator and index register set of a 16-bit core
// Assumes: execution logic drives one write select per cycle
// Notes: no memory decode; registers change only through the write port and the load inputs
//
// Notes on behaviour
// RL1 - two separate 8-bit accumulators, loaded with operands and results
// RL2 - both accumulators also read and written together as 16-bit double
// RL3 - effective address is index register plus constant or accumulator
// RL4 - index registers hold any written value until written again
// RL5 - registers reachable only by instructions, never by memory accesses
// RL6 - datapaths 16 bits wide; extended working register 20 bits
// RL7 - prefetch queue gives at least three code bytes at instruction start
// RL8 - load/store instructions move 16-bit data for double and index regs
// RL9 - first accumulator is upper byte; half write seen next cycle
`timescale 1ns/1ps
module cair_regfile
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire cair_pkg::cair_wr_t wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic [19:0] wr_ext_data,
  input wire logic load_double_acc_instr,
  input wire logic load_index_first_instr,
  input wire logic load_index_second_instr,
  input wire logic [15:0] mem_rd_data,
  input wire cair_pkg::cair_base_t ea_base,
  input wire cair_pkg::cair_ofs_t ea_ofs_sel,
  input wire logic [15:0] ea_const,
  input wire logic code_valid,
  input wire logic [7:0] code_byte,
  input wire logic instr_start,
  input wire logic [1:0] instr_len,
  output logic [7:0] acc_first_reg,
  output logic [7:0] acc_second_reg,
  output logic [15:0] double_acc_reg,
  output logic [15:0] index_first_reg,
  output logic [15:0] index_second_reg,
  output logic [19:0] ext_work_reg,
  output logic [15:0] ea_reg,
  output logic [15:0] store_data_reg,
  output logic code_ready_reg,
  output logic [23:0] code_head_reg,
  output logic code_req_reg
);
  logic [7:0] acc_first_next;
  logic [7:0] acc_second_next;
  logic [15:0] offset;
  logic [15:0] base;
  logic [1:0] pop_count;
  logic [2:0] fill;
  cair_pkg::cair_qstate_t q_state_reg;

  // loads from memory take priority over the register write port
  always_comb
  begin
    acc_first_next = acc_first_reg;
    acc_second_next = acc_second_reg;
    if (load_double_acc_instr) //RL8
    begin
      acc_first_next = mem_rd_data[cair_pkg::DACC_HI_LSB +: 8];
      acc_second_next = mem_rd_data[cair_pkg::DACC_LO_LSB +: 8];
    end
    else if (wr_sel == cair_pkg::CAIR_WR_DOUBLE) //RL2
    begin
      acc_first_next = wr_data[cair_pkg::DACC_HI_LSB +: 8];
      acc_second_next = wr_data[cair_pkg::DACC_LO_LSB +: 8];
    end
    else if (wr_sel == cair_pkg::CAIR_WR_ACC_FIRST) //RL1
      acc_first_next = wr_data[7:0];
    else if (wr_sel == cair_pkg::CAIR_WR_ACC_SECOND) //RL1
      acc_second_next = wr_data[7:0];
  end

  // no address port exists, so memory traffic cannot touch these
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      acc_first_reg <= cair_pkg::ACC_RESET;
      acc_second_reg <= cair_pkg::ACC_RESET;
      double_acc_reg <= {cair_pkg::ACC_RESET, cair_pkg::ACC_RESET};
    end
    else
    begin
      acc_first_reg <= acc_first_next; //RL5
      acc_second_reg <= acc_second_next;
      double_acc_reg <= {acc_first_next, acc_second_next}; //RL9
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      index_first_reg <= cair_pkg::IDX_RESET;
    else if (load_index_first_instr) //RL8
      index_first_reg <= mem_rd_data;
    else if (wr_sel == cair_pkg::CAIR_WR_INDEX_FIRST) //RL4
      index_first_reg <= wr_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      index_second_reg <= cair_pkg::IDX_RESET;
    else if (load_index_second_instr) //RL8
      index_second_reg <= mem_rd_data;
    else if (wr_sel == cair_pkg::CAIR_WR_INDEX_SECOND) //RL4
      index_second_reg <= wr_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ext_work_reg <= cair_pkg::EXT_RESET;
    else if (wr_sel == cair_pkg::CAIR_WR_EXT) //RL6
      ext_work_reg <= wr_ext_data;
  end

  // store data takes the index register selected by wr_sel, else the current double value
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      store_data_reg <= 16'h0000;
    else if (wr_sel == cair_pkg::CAIR_WR_INDEX_FIRST)
      store_data_reg <= index_first_reg; //RL8
    else if (wr_sel == cair_pkg::CAIR_WR_INDEX_SECOND)
      store_data_reg <= index_second_reg; //RL8
    else
      store_data_reg <= double_acc_reg; //RL8
  end

  // effective address from current register values, 16-bit wrap
  always_comb
  begin
    base = (ea_base == cair_pkg::CAIR_BASE_INDEX_FIRST) ? index_first_reg : index_second_reg;
    case (ea_ofs_sel)
      cair_pkg::CAIR_OFS_CONST: offset = ea_const;
      cair_pkg::CAIR_OFS_ACC_FIRST: offset = {8'h00, acc_first_reg};
      cair_pkg::CAIR_OFS_ACC_SECOND: offset = {8'h00, acc_second_reg};
      default: offset = {acc_first_reg, acc_second_reg};
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      ea_reg <= 16'h0000;
    else
      ea_reg <= 16'(base + offset); //RL3
  end

  assign pop_count = (instr_start && code_ready_reg) ? instr_len : 2'h0;

  cair_byte_queue u_queue
  (
    .clk_sys(clk_sys),
    .reset(reset),
    .push(code_valid),
    .push_data(code_byte),
    .pop_count(pop_count),
    .fill_reg(fill),
    .head_reg(code_head_reg)
  );

  // ready only once three bytes sit in the queue
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      q_state_reg <= cair_pkg::CAIR_Q_EMPTY;
    else
    begin
      case (q_state_reg)
        cair_pkg::CAIR_Q_EMPTY:
          q_state_reg <= cair_pkg::CAIR_Q_FILLING;
        cair_pkg::CAIR_Q_FILLING:
          if (fill >= 3'(cair_pkg::QUEUE_BYTES))
            q_state_reg <= cair_pkg::CAIR_Q_READY;
        default:
          if (instr_start)
            q_state_reg <= cair_pkg::CAIR_Q_FILLING;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      code_ready_reg <= 1'b0;
    else if (q_state_reg == cair_pkg::CAIR_Q_FILLING)
      code_ready_reg <= fill >= 3'(cair_pkg::QUEUE_BYTES); //RL7
    else if (q_state_reg == cair_pkg::CAIR_Q_READY)
      code_ready_reg <= !instr_start; //RL7
    else
      code_ready_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      code_req_reg <= 1'b0;
    else
      code_req_reg <= fill < 3'(cair_pkg::QUEUE_DEPTH - 1);
  end

  property p_double_view;
    @(posedge clk_sys) disable iff (reset)
    1'b1 |=> double_acc_reg == {acc_first_reg, acc_second_reg};
  endproperty
  a_double_view: assert property (p_double_view) else $error("double view mismatch"); //RL9

  property p_double_write;
    @(posedge clk_sys) disable iff (reset)
    (wr_sel == cair_pkg::CAIR_WR_DOUBLE && !load_double_acc_instr)
      |=> {acc_first_reg, acc_second_reg} == $past(wr_data);
  endproperty
  a_double_write: assert property (p_double_write) else $error("double write lost"); //RL2

  property p_acc_first;
    @(posedge clk_sys) disable iff (reset)
    (wr_sel == cair_pkg::CAIR_WR_ACC_FIRST && !load_double_acc_instr)
      |=> acc_first_reg == $past(wr_data[7:0]) && $stable(acc_second_reg);
  endproperty
  a_acc_first: assert property (p_acc_first) else $error("first acc write wrong"); //RL1

  property p_index_hold;
    @(posedge clk_sys) disable iff (reset)
    (!load_index_first_instr && wr_sel != cair_pkg::CAIR_WR_INDEX_FIRST)
      |=> $stable(index_first_reg);
  endproperty
  a_index_hold: assert property (p_index_hold) else $error("index changed unwritten"); //RL4

  property p_index_load;
    @(posedge clk_sys) disable iff (reset)
    load_index_second_instr |=> index_second_reg == $past(mem_rd_data);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index load wrong"); //RL8

  property p_ea;
    @(posedge clk_sys) disable iff (reset)
    (ea_ofs_sel == cair_pkg::CAIR_OFS_CONST && ea_base == cair_pkg::CAIR_BASE_INDEX_FIRST)
      |=> ea_reg == 16'($past(index_first_reg) + $past(ea_const));
  endproperty
  a_ea: assert property (p_ea) else $error("effective address wrong"); //RL3

  property p_ext;
    @(posedge clk_sys) disable iff (reset)
    wr_sel == cair_pkg::CAIR_WR_EXT |=> ext_work_reg == $past(wr_ext_data);
  endproperty
  a_ext: assert property (p_ext) else $error("extended register truncated"); //RL6

  property p_code_ready;
    @(posedge clk_sys) disable iff (reset)
    code_ready_reg |-> fill >= 3'(cair_pkg::QUEUE_BYTES);
  endproperty
  a_code_ready: assert property (p_code_ready) else $error("ready with too few bytes"); //RL7

  // ready is held so a late instruction start still finds its bytes
  property p_ready_hold;
    @(posedge clk_sys) disable iff (reset)
    (code_ready_reg && !instr_start) |=> code_ready_reg;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped unused"); //RL7

  property p_no_spurious;
    @(posedge clk_sys) disable iff (reset)
    (wr_sel == cair_pkg::CAIR_WR_NONE && !load_double_acc_instr)
      |=> $stable(acc_first_reg) && $stable(acc_second_reg);
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("acc changed unwritten"); //RL5
endmodule

// ===== tb/cair_code_feeder.sv
// Purpose: fetch side model pushing program bytes into the prefetch queue
// Assumes: byte k of the code stream is 8'h10 plus k
// Notes: pushes at most every other cycle so a late request never overfills
`timescale 1ns/1ps
module cair_code_feeder
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic code_req_reg,
  output logic code_valid,
  output logic [7:0] code_byte
);
  logic [7:0] next_reg;
  initial
  begin
    code_valid = 1'b0;
    code_byte = 8'h00;
    next_reg = 8'h10;
  end
  always @(posedge clk_sys)
  begin
    #1;
    if (reset)
    begin
      next_reg = 8'h10;
      code_valid = 1'b0;
    end
    else if (code_valid)
    begin
      // idle byte line never shows the last value
      code_valid = 1'b0;
      code_byte = ~code_byte;
      next_reg = next_reg + 8'h01;
    end
    else if (code_req_reg && $urandom_range(3) != 0)
    begin
      code_valid = 1'b1;
      code_byte = next_reg;
    end
  end
endmodule

// ===== tb/cair_regfile_bench.sv
// Purpose: self-checking bench for the accumulator and index register set
// Assumes: outputs settle one edge after a request
// Notes: driver queues notes, a negedge monitor compares them
`timescale 1ns/1ps
module cair_regfile_bench;
  typedef struct {int k; logic [23:0] v;} cair_note_t;
  logic clk_sys = 1'b0, reset = 1'b1;
  cair_pkg::cair_wr_t wr_sel = cair_pkg::CAIR_WR_NONE;
  logic [15:0] wr_data = 16'h0000, mem_rd_data = 16'h0000, ea_const = 16'h0000;
  logic [19:0] wr_ext_data = 20'h00000;
  logic ld_d = 1'b0, ld_x = 1'b0, ld_y = 1'b0, instr_start = 1'b0;
  cair_pkg::cair_base_t ea_base = cair_pkg::CAIR_BASE_INDEX_FIRST;
  cair_pkg::cair_ofs_t ea_ofs_sel = cair_pkg::CAIR_OFS_CONST;
  logic [1:0] instr_len = 2'h0;
  logic code_valid, code_ready_reg, code_req_reg;
  logic [7:0] code_byte, acc_first_reg, acc_second_reg, m_a, m_b, n_used;
  logic [15:0] double_acc_reg, index_first_reg, index_second_reg, ea_reg, store_data_reg;
  logic [15:0] m_x, m_y, c, base, ofs;
  logic [19:0] ext_work_reg;
  logic [23:0] code_head_reg;
  cair_note_t note_q[$];
  int n_fail = 0, check_count = 0;
  always #20 clk_sys = ~clk_sys;
  cair_regfile dut_u (.clk_sys(clk_sys), .reset(reset), .wr_sel(wr_sel), .wr_data(wr_data),
    .wr_ext_data(wr_ext_data), .load_double_acc_instr(ld_d), .load_index_first_instr(ld_x),
    .load_index_second_instr(ld_y), .mem_rd_data(mem_rd_data), .ea_base(ea_base),
    .ea_ofs_sel(ea_ofs_sel), .ea_const(ea_const), .code_valid(code_valid),
    .code_byte(code_byte), .instr_start(instr_start), .instr_len(instr_len),
    .acc_first_reg(acc_first_reg), .acc_second_reg(acc_second_reg),
    .double_acc_reg(double_acc_reg), .index_first_reg(index_first_reg),
    .index_second_reg(index_second_reg), .ext_work_reg(ext_work_reg), .ea_reg(ea_reg),
    .store_data_reg(store_data_reg), .code_ready_reg(code_ready_reg),
    .code_head_reg(code_head_reg), .code_req_reg(code_req_reg));
  cair_code_feeder feed_u (.clk_sys(clk_sys), .reset(reset), .code_req_reg(code_req_reg),
    .code_valid(code_valid), .code_byte(code_byte));
  function automatic logic [23:0] obs(input int k);
    case (k)
      0: return 24'(acc_first_reg);
      1: return 24'(acc_second_reg);
      2: return 24'(double_acc_reg);
      3: return 24'(index_first_reg);
      4: return 24'(index_second_reg);
      5: return 24'(ext_work_reg);
      6: return 24'(ea_reg);
      7: return 24'(store_data_reg);
      8: return code_head_reg;
      9: return 24'(code_ready_reg);
      default: return 24'(code_req_reg);
    endcase
  endfunction
  function automatic logic [7:0] code_at(input logic [7:0] k);
    return 8'h10 + k;
  endfunction
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic note(input int k, input logic [23:0] v);
    note_q.push_back('{k, v});
  endtask
  task automatic cmp_note(input cair_note_t n);
    check_count++;
    if (obs(n.k) !== n.v)
    begin
      n_fail++;
      $display("MISMATCH t=%0t kind %0d got %h want %h", $time, n.k, obs(n.k), n.v);
    end
  endtask
  always @(negedge clk_sys)
    while (note_q.size() > 0)
      cmp_note(note_q.pop_front());
  task automatic wr(input cair_pkg::cair_wr_t s, input logic [15:0] d);
    wr_sel = s;
    wr_data = d;
    step();
  endtask
  // load pulse fights a plain write to the same target
  task automatic ld(input int w, input logic [15:0] m);
    mem_rd_data = m;
    ld_d = (w == 2);
    ld_x = (w == 3);
    ld_y = (w == 4);
    wr_sel = cair_pkg::cair_wr_t'(w + 1);
    wr_data = ~m;
    step();
    note(w, 24'(m));
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    report_and_stop();
  end
  initial
  begin
    void'($urandom(67));
    repeat (20) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    for (int k = 0; k < 11; k++)
      note(k, 24'h000000);
    step();
    {m_b, m_x, m_y} = 40'h0;
    for (int i = 0; i < 8; i++)
    begin
      m_a = 8'($urandom);
      wr(cair_pkg::CAIR_WR_ACC_FIRST, {8'h00, m_a});
      note(0, 24'(m_a));
      note(2, 24'({m_a, m_b}));
      m_b = 8'($urandom);
      wr(cair_pkg::CAIR_WR_ACC_SECOND, {8'h00, m_b});
      note(1, 24'(m_b));
      note(2, 24'({m_a, m_b}));
    end
    {m_a, m_b} = 16'($urandom);
    wr(cair_pkg::CAIR_WR_DOUBLE, {m_a, m_b});
    note(0, 24'(m_a));
    note(1, 24'(m_b));
    $display("accumulator test done");
    m_x = 16'($urandom);
    m_y = 16'($urandom);
    wr(cair_pkg::CAIR_WR_INDEX_FIRST, m_x);
    wr(cair_pkg::CAIR_WR_INDEX_SECOND, m_y);
    wr_ext_data = {4'ha, 16'($urandom)};
    wr(cair_pkg::CAIR_WR_EXT, 16'h0000);
    note(5, 24'(wr_ext_data));
    // memory traffic alone must leave the index and double registers alone
    wr_sel = cair_pkg::CAIR_WR_NONE;
    repeat (6)
    begin
      mem_rd_data = 16'($urandom);
      step();
      note(3, 24'(m_x));
      note(4, 24'(m_y));
      note(2, 24'({m_a, m_b}));
    end
    for (int w = 2; w < 5; w++)
    begin
      c = 16'($urandom);
      ld(w, c);
      if (w == 2)
        {m_a, m_b} = c;
      else if (w == 3)
        m_x = c;
      else
        m_y = c;
    end
    {ld_d, ld_x, ld_y} = 3'h0;
    wr(cair_pkg::CAIR_WR_INDEX_FIRST, m_x);
    note(7, 24'(m_x));
    wr(cair_pkg::CAIR_WR_INDEX_SECOND, m_y);
    note(7, 24'(m_y));
    wr_sel = cair_pkg::CAIR_WR_NONE;
    step();
    note(7, 24'({m_a, m_b}));
    $display("index and load test done");
    for (int b = 0; b < 2; b++)
      for (int o = 0; o < 4; o++)
      begin
        c = 16'($urandom);
        ea_base = cair_pkg::cair_base_t'(b);
        ea_ofs_sel = cair_pkg::cair_ofs_t'(o);
        ea_const = c;
        step();
        base = (b == 1) ? m_y : m_x;
        ofs = (o == 0) ? c : (o == 1) ? {8'h00, m_a} : (o == 2) ? {8'h00, m_b} : {m_a, m_b};
        note(6, 24'(16'(base + ofs)));
      end
    $display("address test done");
    n_used = 8'h00;
    repeat (5)
    begin
      for (int i = 0; i < 300 && code_ready_reg !== 1'b1; i++)
        step();
      note(8, {code_at(n_used + 8'h02), code_at(n_used + 8'h01), code_at(n_used)});
      note(9, 24'h000001);
      note(10, 24'h000000);
      instr_start = 1'b1;
      instr_len = 2'($urandom_range(3, 1));
      step();
      instr_start = 1'b0;
      n_used = n_used + 8'(instr_len);
      step();
    end
    $display("prefetch test done");
    step();
    report_and_stop();
  end
endmodule
